/* design/dtc_map.svh */
// Function
// RL1: Two timers, modes 0-3 plus mode 6
// RL2: Mode 0: 8-bit counter behind divide-by-32
// RL3: Mode 1: full 16-bit count
// RL4: Mode 2: low byte reloads from high byte
// RL5: Timer 1 in mode 3 holds its count
// RL6: Timer 0 mode 3 splits into two counters
// RL7: Timer 1 rate stays usable in mode 3
// RL8: Mode 6: PWM with 256-clock period
// RL9: Two mode bits plus aux bit select mode
// RL10: Control register: run bits, overflow flags, reset zero
// RL11: Mode 0 low five bits prescale, carry high
// RL12: Split high counter uses timer 1 run/flag
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Register indices; byte address is four times the index
`define DTC_IDX_CONTROL    8'h88
`define DTC_IDX_MODE       8'h89
`define DTC_IDX_LOW0       8'h8a
`define DTC_IDX_LOW1       8'h8b
`define DTC_IDX_HIGH0      8'h8c
`define DTC_IDX_HIGH1      8'h8d
`define DTC_IDX_AUX_MODE   8'h8f
`define DTC_IDX_INT_STAT   8'h90
`define DTC_IDX_INT_MASK   8'h91

// Control register fields
`define DTC_BIT_OVF1       7
`define DTC_BIT_RUN1       6
`define DTC_BIT_OVF0       5
`define DTC_BIT_RUN0       4
// Mode register fields (low bit of each pair)
`define DTC_BIT_T1_MODE    4
`define DTC_BIT_T0_MODE    0
// Aux mode register fields
`define DTC_BIT_T1_MODE2   4
`define DTC_BIT_T0_MODE2   0

// Reset values
`define DTC_RST_BYTE       8'h00

// Timing: timer clock is the system clock divided by this
`define DTC_TCLK_DIV       2
// Prescaler terminal value in mode 0
`define DTC_PRESCALE_TOP   5'h1f

`endif

/* design/dtc_pkg.sv */
package dtc_pkg;

  // Timer mode, {aux bit, mode bit1, mode bit0}
  typedef enum logic [2:0] {
    DTC_MODE0 = 3'b000,
    DTC_MODE1 = 3'b001,
    DTC_MODE2 = 3'b010,
    DTC_MODE3 = 3'b011,
    DTC_MODE6 = 3'b110
  } dtc_mode_t;

  // Whole state of the block
  typedef struct packed {
    logic        runCtl0;     // Timer 0 run
    logic        runCtl1;     // Timer 1 run
    logic        ovfFlag0;    // Timer 0 overflow
    logic        ovfFlag1;    // Timer 1 overflow
    logic [1:0]  t0ModeLo;    // Timer 0 mode bits 1:0
    logic [1:0]  t1ModeLo;    // Timer 1 mode bits 1:0
    logic        t0ModeBit2;  // Timer 0 aux mode bit
    logic        t1ModeBit2;  // Timer 1 aux mode bit
    logic [7:0]  countLow0;
    logic [7:0]  countHigh0;
    logic [7:0]  countLow1;
    logic [7:0]  countHigh1;
    logic [7:0]  divCnt;      // Timer clock divider
    logic [1:0]  intStat;     // Sticky overflow events
    logic [1:0]  intMask;     // Interrupt enables
    logic        irq;
    logic        pwm0;
    logic        pwm1;
    logic        baudTick;
    logic        dataPh;      // Bus data phase pending
    logic        dataWr;
    logic [7:0]  dataIdx;
    logic [31:0] rdata;
    logic        readyOut;
  } dtc_state_t;

endpackage : dtc_pkg

/* design/dtc_top.sv */
`include "dtc_map.svh"

module dtc_top #(
  parameter int TCLK_DIV = `DTC_TCLK_DIV  // System clocks per timer clock, 1..256
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Timer outputs
  output logic             irq,
  output logic             pwmOut0,
  output logic             pwmOut1,
  output logic             baudTick
);

  dtc_pkg::dtc_state_t s_q;   // Registered state
  dtc_pkg::dtc_state_t s_d;   // Next state
  logic                tick;  // One-cycle timer clock enable
  logic                busWr; // Write data phase this cycle
  dtc_pkg::dtc_mode_t  mode0;
  dtc_pkg::dtc_mode_t  mode1;

  // One step of a timer in modes 0, 1, 2 and 6; returns {overflow, high, low}
  function automatic logic [16:0] stepTimer(input dtc_pkg::dtc_mode_t m,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic       ov;
    logic [7:0] h;
    logic [7:0] l;
    ov = 1'b0;
    h  = hi;
    l  = lo;
    case (m)
      dtc_pkg::DTC_MODE0: begin
        // Low five bits prescale by 32, upper three stay put
        if (lo[4:0] == `DTC_PRESCALE_TOP) begin // [RL2] [RL11]
          l[4:0] = 5'h00;
          ov     = (hi == 8'hff);
          h      = hi + 8'h01;
        end else begin
          l[4:0] = lo[4:0] + 5'h01;
        end
      end
      dtc_pkg::DTC_MODE1: begin
        ov     = ({hi, lo} == 16'hffff); // [RL3]
        {h, l} = {hi, lo} + 16'h0001;
      end
      dtc_pkg::DTC_MODE2: begin
        // Reload from high byte on wrap
        ov = (lo == 8'hff);
        l  = ov ? hi : lo + 8'h01; // [RL4]
      end
      dtc_pkg::DTC_MODE6: begin
        // Free wrap of the low byte gives a 256-clock period; high byte is duty
        ov = (lo == 8'hff);
        l  = lo + 8'h01; // [RL8]
      end
      default: begin
        // Reserved codes hold the count
        ov = 1'b0;
      end
    endcase
    return {ov, h, l};
  endfunction

  // Read view of the registers
  function automatic logic [31:0] readReg(input dtc_pkg::dtc_state_t r, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `DTC_IDX_CONTROL:  v = {r.ovfFlag1, r.runCtl1, r.ovfFlag0, r.runCtl0, 4'h0};
      `DTC_IDX_MODE:     v = {2'h0, r.t1ModeLo, 2'h0, r.t0ModeLo};
      `DTC_IDX_AUX_MODE: v = {3'h0, r.t1ModeBit2, 3'h0, r.t0ModeBit2};
      `DTC_IDX_LOW0:     v = r.countLow0;
      `DTC_IDX_HIGH0:    v = r.countHigh0;
      `DTC_IDX_LOW1:     v = r.countLow1;
      `DTC_IDX_HIGH1:    v = r.countHigh1;
      `DTC_IDX_INT_STAT: v = {6'h00, r.intStat};
      `DTC_IDX_INT_MASK: v = {6'h00, r.intMask};
      default:           v = 8'h00; // Unmapped reads as zero
    endcase
    return {24'h000000, v};
  endfunction

  // Mode decode from mode and aux mode bits
  assign mode0 = dtc_pkg::dtc_mode_t'({s_q.t0ModeBit2, s_q.t0ModeLo}); // [RL9]
  assign mode1 = dtc_pkg::dtc_mode_t'({s_q.t1ModeBit2, s_q.t1ModeLo}); // [RL9]
  assign tick  = (s_q.divCnt == 8'(TCLK_DIV - 1));
  assign busWr = s_q.dataPh & s_q.dataWr;

  // Next-state logic: timers first, then bus writes, then flags
  always_comb begin
    logic [16:0] r;
    logic [8:0]  inc;
    logic        ovf0;
    logic        ovf1;
    logic        t1Run;
    logic        t1Flag;
    logic [7:0]  wb;
    r      = 17'h00000;
    inc    = 9'h000;
    ovf0   = 1'b0;
    ovf1   = 1'b0;
    t1Flag = 1'b0;
    t1Run  = 1'b0; // Decided below once the split mode is known
    wb     = hwdata[7:0];
    s_d    = s_q;
    s_d.baudTick = 1'b0;
    s_d.divCnt   = tick ? 8'h00 : s_q.divCnt + 8'h01;

    // Timer 0
    if (mode0 == dtc_pkg::DTC_MODE3) begin
      // Split: low byte on own run bit, high byte borrows timer 1 run bit
      if (tick && s_q.runCtl0) begin // [RL6]
        inc         = {1'b0, s_q.countLow0} + 9'h001;
        s_d.countLow0 = inc[7:0];
        ovf0        = inc[8];
      end
      if (tick && s_q.runCtl1) begin // [RL6] [RL12]
        inc          = {1'b0, s_q.countHigh0} + 9'h001;
        s_d.countHigh0 = inc[7:0];
        ovf1         = inc[8];
      end
    end else if (tick && s_q.runCtl0) begin // [RL1] [RL10]
      r              = stepTimer(mode0, s_q.countHigh0, s_q.countLow0);
      s_d.countHigh0 = r[15:8];
      s_d.countLow0  = r[7:0];
      ovf0           = r[16];
    end

    // Timer 1: free-runs for the serial port while timer 0 holds its run bit
    t1Run = s_q.runCtl1 | (mode0 == dtc_pkg::DTC_MODE3);
    if (mode1 == dtc_pkg::DTC_MODE3) begin
      // Count frozen, but the prescaled rate still reaches the serial port
      s_d.baudTick = tick; // [RL5] [RL7]
    end else if (tick && t1Run) begin // [RL1]
      r              = stepTimer(mode1, s_q.countHigh1, s_q.countLow1);
      s_d.countHigh1 = r[15:8];
      s_d.countLow1  = r[7:0];
      s_d.baudTick   = r[16]; // [RL7]
      t1Flag         = r[16] & (mode0 != dtc_pkg::DTC_MODE3);
    end
    // Flag 1 comes from the split high byte or from timer 1 itself
    ovf1 = ovf1 | t1Flag; // [RL12]

    // Register writes; a software count write wins over counting
    if (busWr) begin
      case (s_q.dataIdx)
        `DTC_IDX_CONTROL: begin
          s_d.runCtl0  = wb[`DTC_BIT_RUN0]; // [RL10]
          s_d.runCtl1  = wb[`DTC_BIT_RUN1]; // [RL10]
          s_d.ovfFlag0 = wb[`DTC_BIT_OVF0];
          s_d.ovfFlag1 = wb[`DTC_BIT_OVF1];
        end
        `DTC_IDX_MODE: begin
          s_d.t0ModeLo = wb[`DTC_BIT_T0_MODE +: 2]; // [RL9]
          s_d.t1ModeLo = wb[`DTC_BIT_T1_MODE +: 2]; // [RL9]
        end
        `DTC_IDX_AUX_MODE: begin
          s_d.t0ModeBit2 = wb[`DTC_BIT_T0_MODE2]; // [RL9]
          s_d.t1ModeBit2 = wb[`DTC_BIT_T1_MODE2]; // [RL9]
        end
        `DTC_IDX_LOW0:     s_d.countLow0  = wb;
        `DTC_IDX_HIGH0:    s_d.countHigh0 = wb;
        `DTC_IDX_LOW1:     s_d.countLow1  = wb;
        `DTC_IDX_HIGH1:    s_d.countHigh1 = wb;
        `DTC_IDX_INT_STAT: s_d.intStat    = s_q.intStat & ~wb[1:0]; // Write one to clear
        `DTC_IDX_INT_MASK: s_d.intMask    = wb[1:0];
        default: begin
          // Unmapped writes are dropped
          s_d.intMask = s_d.intMask;
        end
      endcase
    end

    // Hardware set beats a software clear in the same cycle
    s_d.ovfFlag0 = s_d.ovfFlag0 | ovf0; // [RL10] [RL11]
    s_d.ovfFlag1 = s_d.ovfFlag1 | ovf1; // [RL10] [RL12]
    s_d.intStat  = s_d.intStat | {ovf1, ovf0};
    s_d.irq      = |(s_d.intStat & s_d.intMask);

    // PWM: high while the count is below the duty byte
    s_d.pwm0 = (dtc_pkg::dtc_mode_t'({s_d.t0ModeBit2, s_d.t0ModeLo}) == dtc_pkg::DTC_MODE6)
               && (s_d.countLow0 < s_d.countHigh0); // [RL8]
    s_d.pwm1 = (dtc_pkg::dtc_mode_t'({s_d.t1ModeBit2, s_d.t1ModeLo}) == dtc_pkg::DTC_MODE6)
               && (s_d.countLow1 < s_d.countHigh1); // [RL8]

    // Bus address phase; zero wait states, read data taken from next state
    s_d.readyOut = 1'b1;
    s_d.dataPh   = hsel & htrans[1] & hready;
    s_d.dataWr   = hwrite;
    s_d.dataIdx  = haddr[9:2];
    if (hsel && htrans[1] && hready && !hwrite) begin
      s_d.rdata = readReg(s_d, haddr[9:2]);
    end
  end

  // State register; everything clears on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0; // [RL10]
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign hreadyout = s_q.readyOut;
  assign hresp     = 1'b0 & s_q.readyOut;
  assign hrdata    = s_q.rdata;
  assign irq       = s_q.irq;
  assign pwmOut0   = s_q.pwm0;
  assign pwmOut1   = s_q.pwm1;
  assign baudTick  = s_q.baudTick;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sCtlRead;
    hsel && htrans[1] && hready && !hwrite && (haddr[9:2] == `DTC_IDX_CONTROL) && !busWr;
  endsequence
  sequence sCtlShown;
    hrdata[`DTC_BIT_RUN0] == s_q.runCtl0 && hrdata[`DTC_BIT_OVF1] == s_q.ovfFlag1;
  endsequence

  // Prescaler carry clears the five low bits and bumps the high byte
  a_mode0_carry: assert property ( // [RL2] [RL11]
    tick && s_q.runCtl0 && mode0 == dtc_pkg::DTC_MODE0 && s_q.countLow0[4:0] == 5'h1f && !busWr
    |=> s_q.countLow0[4:0] == 5'h00 && s_q.countHigh0 == $past(s_q.countHigh0) + 8'h01)
    else $error("mode 0 prescaler carry wrong");

  // Full 16-bit wrap returns to zero and raises flag 0
  a_mode1_wrap: assert property ( // [RL3]
    tick && s_q.runCtl0 && mode0 == dtc_pkg::DTC_MODE1 && {s_q.countHigh0, s_q.countLow0} == 16'hffff && !busWr
    |=> {s_q.countHigh0, s_q.countLow0} == 16'h0000 && s_q.ovfFlag0)
    else $error("mode 1 wrap or flag wrong");

  // Timer 1 low byte reloads from its high byte on wrap
  a_mode2_reload: assert property ( // [RL4]
    tick && s_q.runCtl1 && mode1 == dtc_pkg::DTC_MODE2 && s_q.countLow1 == 8'hff && !busWr
    |=> s_q.countLow1 == $past(s_q.countHigh1))
    else $error("mode 2 reload wrong");

  // Timer 1 in mode 3 never moves, whatever its run bit says
  a_t1_halted: assert property ( // [RL5]
    mode1 == dtc_pkg::DTC_MODE3 && !busWr |=> $stable(s_q.countLow1) && $stable(s_q.countHigh1))
    else $error("timer 1 counted in mode 3");

  // Split high byte runs on the timer 1 run bit and sets flag 1
  a_split_high: assert property ( // [RL6] [RL12]
    tick && s_q.runCtl1 && mode0 == dtc_pkg::DTC_MODE3 && s_q.countHigh0 == 8'hff && !busWr
    |=> s_q.countHigh0 == 8'h00 && s_q.ovfFlag1 && s_q.intStat[1])
    else $error("split high counter wrong");

  // Frozen timer 1 still pulses once per timer clock; needs a divider above 1
  a_baud_live: assert property ( // [RL7]
    tick && mode1 == dtc_pkg::DTC_MODE3 |=> baudTick ##1 !baudTick)
    else $error("baud rate lost in mode 3");

  // Zero duty keeps the pulse output low for the whole period
  a_pwm_duty: assert property ( // [RL8]
    mode0 == dtc_pkg::DTC_MODE6 && s_q.countHigh0 == 8'h00 |-> !pwmOut0)
    else $error("pwm high at zero duty");

  // Overflow flag stays until software writes it
  a_flag_sticky: assert property ( // [RL10]
    s_q.ovfFlag0 && !busWr |=> s_q.ovfFlag0)
    else $error("overflow flag lost");

  // Aux mode bit follows the written byte
  a_mode_write: assert property ( // [RL9]
    busWr && s_q.dataIdx == `DTC_IDX_AUX_MODE
    |=> s_q.t0ModeBit2 == $past(hwdata[`DTC_BIT_T0_MODE2]))
    else $error("aux mode bit not written");

  // Control read returns the live timer 0 run bit and timer 1 flag bit
  a_ctl_read: assert property ( // [RL10]
    sCtlRead |=> sCtlShown)
    else $error("control read mismatch");

  // Level interrupt follows an enabled pending event
  a_irq_level: assert property (
    s_q.intStat[0] && s_q.intMask[0] |-> irq)
    else $error("irq low with pending event");

  // Stopped timer 0 keeps its count outside split mode
  a_run_hold: assert property ( // [RL10]
    !s_q.runCtl0 && mode0 != dtc_pkg::DTC_MODE3 && !busWr
    |=> $stable(s_q.countLow0) && $stable(s_q.countHigh0))
    else $error("timer 0 counted while stopped");

  // Timer 1 is still unless its run bit or split mode drives it
  a_t1_run_hold: assert property ( // [RL10] [RL12]
    !s_q.runCtl1 && mode0 != dtc_pkg::DTC_MODE3 && !busWr
    |=> $stable(s_q.countLow1) && $stable(s_q.countHigh1))
    else $error("timer 1 counted while stopped");

  // Split low byte wraps on its own and raises flag 0
  a_split_low: assert property ( // [RL6]
    tick && s_q.runCtl0 && mode0 == dtc_pkg::DTC_MODE3 && s_q.countLow0 == 8'hff && !busWr
    |=> s_q.countLow0 == 8'h00 && s_q.ovfFlag0)
    else $error("split low counter wrong");

  // In split mode timer 1 itself never touches flag 1
  a_split_quiet: assert property ( // [RL12]
    tick && mode0 == dtc_pkg::DTC_MODE3 && !s_q.runCtl1 && !s_q.ovfFlag1 && !busWr
    |=> !s_q.ovfFlag1)
    else $error("flag 1 set by idle split pair");

  // Mode 6 period: low byte wraps after 256 ticks, duty byte untouched
  a_mode6_wrap: assert property ( // [RL8]
    tick && s_q.runCtl0 && mode0 == dtc_pkg::DTC_MODE6 && s_q.countLow0 == 8'hff && !busWr
    |=> s_q.countLow0 == 8'h00 && $stable(s_q.countHigh0) && s_q.ovfFlag0)
    else $error("mode 6 wrap wrong");

  // Mode 0 counts only in the five prescaler bits and the high byte
  a_mode0_upper: assert property ( // [RL11]
    tick && s_q.runCtl0 && mode0 == dtc_pkg::DTC_MODE0 && !busWr
    |=> $stable(s_q.countLow0[7:5]))
    else $error("mode 0 disturbed low byte top bits");

  // Timer 1 wrap in mode 2 feeds the serial port and sets flag 1
  a_t1_overflow: assert property ( // [RL4] [RL10]
    tick && s_q.runCtl1 && mode0 != dtc_pkg::DTC_MODE3 && mode1 == dtc_pkg::DTC_MODE2
    && s_q.countLow1 == 8'hff && !busWr
    |=> baudTick && s_q.ovfFlag1)
    else $error("timer 1 overflow lost");

  // Writing one clears a status bit when no event lands in that cycle
  a_stat_clear: assert property (
    busWr && s_q.dataIdx == `DTC_IDX_INT_STAT && hwdata[0] && !tick
    |=> !s_q.intStat[0])
    else $error("status bit not cleared");

endmodule // dtc_top

/* sim/dual_timer_counter_tb_top.sv */
`include "dtc_map.svh"

module dual_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Slow timer clock so a bus access never straddles two ticks
  localparam int TDIV = 64;

  // Clock, reset and bus
  logic        clk, rst, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // Slave answers and timer outputs
  logic        hreadyout, hresp, irq, pwmOut0, pwmOut1, baudTick;
  int          fails, n_checks, ticks;

  dtc_top #(.TCLK_DIV(TDIV)) i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .pwmOut0(pwmOut0), .pwmOut1(pwmOut1), .baudTick(baudTick)
  );

  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single word transfer; waits on the slave's ready, never on a fixed count
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Read a register and compare it
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string name);
    xfer(1'b0, idx, 32'h0);
    check(name, rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
  endtask

  // Wait for the next timer tick, seen through the baud pulse
  task automatic wait_tick();
    do @(posedge clk); while (baudTick !== 1'b1);
  endtask

  // Let exactly one timer tick pass with timer 0 set up, then compare the result
  task automatic one_tick(input logic [7:0] md, input logic [7:0] aux, input logic [7:0] lo,
                          input logic [7:0] hi, input logic [7:0] ctl, input logic [7:0] eLo,
                          input logic [7:0] eHi, input logic [7:0] eCtl);
    xfer(1'b1, `DTC_IDX_MODE, {24'h0, md});
    xfer(1'b1, `DTC_IDX_AUX_MODE, {24'h0, aux});
    xfer(1'b1, `DTC_IDX_LOW0, {24'h0, lo});
    xfer(1'b1, `DTC_IDX_HIGH0, {24'h0, hi});
    wait_tick();
    xfer(1'b1, `DTC_IDX_CONTROL, {24'h0, ctl});
    wait_tick();
    rchk(`DTC_IDX_CONTROL, {24'h0, eCtl}, "control");
    xfer(1'b1, `DTC_IDX_CONTROL, 32'h0);
    rchk(`DTC_IDX_LOW0, {24'h0, eLo}, "low0");
    rchk(`DTC_IDX_HIGH0, {24'h0, eHi}, "high0");
  endtask

  // Verdict; reached from the tests or from the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly 1000 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk(`DTC_IDX_CONTROL, 32'h0, "control reset");
    rchk(`DTC_IDX_MODE, 32'h0, "mode reset");
    rchk(8'h8e, 32'h0, "unmapped");
    xfer(1'b1, `DTC_IDX_AUX_MODE, 32'h11);
    rchk(`DTC_IDX_AUX_MODE, 32'h11, "aux mode");
    // Timer 1 parked in mode 3: frozen, yet its tick keeps coming
    xfer(1'b1, `DTC_IDX_LOW1, 32'h55);
    xfer(1'b1, `DTC_IDX_MODE, 32'h30);
    xfer(1'b1, `DTC_IDX_AUX_MODE, 32'h00);
    ticks = 0;
    repeat (2 * TDIV) begin
      @(posedge clk);
      if (baudTick === 1'b1) ticks++;
    end
    check("baud ticks", ticks, 32'd2);
    one_tick(8'h31, 8'h00, 8'hff, 8'hff, 8'h10, 8'h00, 8'h00, 8'h30);
    one_tick(8'h30, 8'h00, 8'hff, 8'hff, 8'h10, 8'he0, 8'h00, 8'h30);
    one_tick(8'h30, 8'h00, 8'hbf, 8'h07, 8'h10, 8'ha0, 8'h08, 8'h10);
    one_tick(8'h32, 8'h00, 8'hff, 8'h9c, 8'h10, 8'h9c, 8'h9c, 8'h30);
    xfer(1'b1, `DTC_IDX_INT_STAT, 32'h3);
    one_tick(8'h33, 8'h00, 8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'hf0);
    rchk(`DTC_IDX_LOW1, 32'h55, "low1 frozen");
    // Sticky events, mask and write-one-to-clear
    rchk(`DTC_IDX_INT_STAT, 32'h3, "int status");
    #1 check("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, `DTC_IDX_INT_MASK, 32'h1);
    #1 check("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b1, `DTC_IDX_INT_STAT, 32'h1);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    rchk(`DTC_IDX_INT_STAT, 32'h2, "int status w1c");
    xfer(1'b1, `DTC_IDX_INT_MASK, 32'h3);
    #1 check("irq timer1", {31'h0, irq}, 32'h1);
    xfer(1'b1, `DTC_IDX_INT_STAT, 32'h2);
    #1 check("irq none", {31'h0, irq}, 32'h0);
    // Mode 6: low byte wraps at 256 and the output compares low against high
    one_tick(8'h32, 8'h01, 8'hff, 8'h80, 8'h10, 8'h00, 8'h80, 8'h30);
    repeat (2) @(posedge clk);
    #1 check("pwm high", {31'h0, pwmOut0}, 32'h1);
    xfer(1'b1, `DTC_IDX_HIGH0, 32'h00);
    repeat (2) @(posedge clk);
    #1 check("pwm low", {31'h0, pwmOut0}, 32'h0);
    check("pwm1 idle", {31'h0, pwmOut1}, 32'h0);
    // Timer 1 in mode 2: reload on wrap, overflow gives the baud pulse and flag 1
    xfer(1'b1, `DTC_IDX_MODE, 32'h20);
    xfer(1'b1, `DTC_IDX_HIGH1, 32'hfe);
    xfer(1'b1, `DTC_IDX_LOW1, 32'hff);
    xfer(1'b1, `DTC_IDX_CONTROL, 32'h40);
    wait_tick();
    rchk(`DTC_IDX_LOW1, 32'hfe, "low1 reload");
    rchk(`DTC_IDX_CONTROL, 32'hc0, "control t1");
    rchk(`DTC_IDX_INT_STAT, 32'h3, "int status t1");
    #1 check("irq t1", {31'h0, irq}, 32'h1);
    xfer(1'b1, `DTC_IDX_CONTROL, 32'h0);
    wrap_up();
  end
endmodule // dual_timer_counter_tb_top
